// ==== src/gioc_defs.svh ====
// Offsets, field positions, reset values and codes of the I/O cell.
`ifndef GIOC_DEFS_SVH
`define GIOC_DEFS_SVH

// ===========================================================
// Register map
`define GIOC_CTRL_OFFSET 4'h0
`define GIOC_STATUS_OFFSET 4'h4
`define GIOC_AW 4

// ===========================================================
// Control register fields
`define GIOC_CTRL_W 13
`define GIOC_CTRL_RESET 13'h0000
`define GIOC_MODE_LSB 0
`define GIOC_MODE_MSB 2
`define GIOC_IN_REG 3
`define GIOC_IN_FALL 4
`define GIOC_OUT_REG 5
`define GIOC_OUT_FALL 6
`define GIOC_OE_FALL 7
`define GIOC_OUT_INV 8
`define GIOC_DDR 9
`define GIOC_ALT 10
`define GIOC_PULL_DOWN 11
`define GIOC_DIFF 12

// ===========================================================
// Mode codes
`define GIOC_MODE_UNUSED 3'h0
`define GIOC_MODE_INPUT 3'h1
`define GIOC_MODE_OUTPUT 3'h2
`define GIOC_MODE_BIDIR 3'h3
`define GIOC_MODE_CLKOUT 3'h4

// ===========================================================
// Bus answers
`define GIOC_RESP_OKAY 2'h0
`define GIOC_RESP_SLVERR 2'h2

`endif

// ==== src/gioc_pkg.sv ====
// Types shared by the I/O cell modules.
package gioc_pkg;

    // ===========================================================
    // Pin modes
    typedef enum {
        mode_unused,
        mode_input,
        mode_output,
        mode_bidir,
        mode_clkout
    } gioc_mode_type;

endpackage : gioc_pkg

// ==== src/gioc_edge_reg.sv ====
// Register that loads on a selectable edge pulse of a sampled clock.
`timescale 1ns/1ps

module gioc_edge_reg #(
    parameter int WIDTH = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic rise_pulse,
    input wire logic fall_pulse,
    input wire logic use_fall,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] next_q;

    // ===========================================================
    // Parameter check
    initial begin
        if (WIDTH < 1) begin
            $error("Edge register width must be at least one.");
        end
    end

    // ===========================================================
    // Load on the chosen edge
    always_comb begin
        next_q = q;
        if (use_fall ? fall_pulse : rise_pulse) begin
            next_q = d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

endmodule : gioc_edge_reg

// ==== src/gioc_cell.sv ====
// General-purpose I/O logic cell with an AXI4-Lite control port.
`timescale 1ns/1ps
`include "gioc_defs.svh"

// Contract
// - Input mode enables only the receive path, optionally registered on a chosen capture edge.
// - The alternate input follows the pad with no capture register in its path.
// - Double-rate input samples the pad on both capture clock edges into two streams.
// - Output mode enables only the transmit path, optionally registered on a chosen launch edge.
// - In output and bidirectional modes the transmitted value can be inverted.
// - Double-rate output captures two bits on both launch edges and muxes them onto the pad.
// - Bidirectional mode runs the receive, transmit and enable paths but not the alternate input, input on capture edges, output and enable on launch edges.
// - In bidirectional mode receive and transmit registering are chosen independently.
// - Clock output mode drives the pad from the global clock line, not core data.
// - The alternate input feeds another block directly, bypassing the core interface.
// - The output-enable register decides whether the pad driver is on when GIOC_OUT_REG is set; otherwise core_oe decides it directly.
// - Input registers capture the pad before the core; output registers hold core data.
// - During configuration pins get a weak pull-up, differential pins float.
// - Unused pins in user mode float with a pull-up, or a pull-down if chosen; differential pins get no pull-down.
// - Double-rate input puts the rising sample on bit 0 and the falling on bit 1.
module gioc_cell #(
    parameter int ADDR_WIDTH = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic config_active,
    input wire logic [1:0] core_out,
    input wire logic core_oe,
    input wire logic capture_clock,
    input wire logic launch_clock,
    input wire logic global_clock_line,
    input wire logic pad_in,
    output logic [1:0] core_in,
    output logic alternate_input,
    output logic pad_out,
    output logic pad_oe,
    output logic pad_pull_up,
    output logic pad_pull_down
);

    // ===========================================================
    // Declarations
    logic aw_held, next_aw_held, w_held, next_w_held;
    logic [`GIOC_AW-1:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic [`GIOC_CTRL_W-1:0] ctrl, next_ctrl;
    logic next_awready, next_wready, next_arready;
    logic next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata, merged, status;
    logic [3:0] sync1, sync2, next_sync1;
    logic cap_prev, lau_prev, pad_s2, cap_s2, lau_s2, glob_s2;
    logic cap_rise, cap_fall, lau_rise, lau_fall;
    logic in_q, in_rise_q, in_fall_q, out_q, oe_q, dout_rise_q, dout_fall_q;
    logic ddr_on, tx_val, oe_val;
    logic [1:0] rx_val, next_core_in;
    logic next_alt, next_pad_out, next_pad_oe, next_pull_up, next_pull_down;
    gioc_pkg::gioc_mode_type mode;

    // ===========================================================
    // Functions
    function automatic gioc_pkg::gioc_mode_type decode_mode(
        input logic [2:0] code
    );
        case (code)
            `GIOC_MODE_INPUT: decode_mode = gioc_pkg::mode_input;
            `GIOC_MODE_OUTPUT: decode_mode = gioc_pkg::mode_output;
            `GIOC_MODE_BIDIR: decode_mode = gioc_pkg::mode_bidir;
            `GIOC_MODE_CLKOUT: decode_mode = gioc_pkg::mode_clkout;
            default: decode_mode = gioc_pkg::mode_unused;
        endcase
    endfunction : decode_mode

    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] strb
    );
        merge_bytes = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                merge_bytes[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
    endfunction : merge_bytes

    // ===========================================================
    // Parameter check
    initial begin
        if (ADDR_WIDTH < `GIOC_AW) begin
            $error("Address width too small for the register map.");
        end
    end

    // ===========================================================
    // Register bus
    assign mode = decode_mode(ctrl[`GIOC_MODE_MSB:`GIOC_MODE_LSB]);
    assign merged = merge_bytes({{(32-`GIOC_CTRL_W){1'b0}}, ctrl},
        w_data, w_strb);
    assign status = {26'h0000000, alternate_input, core_in, pad_out,
        pad_oe, pad_s2};

    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_ctrl = ctrl;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr[`GIOC_AW-1:0];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (aw_held && w_held && !s_axi_bvalid) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = `GIOC_RESP_OKAY;
            case (aw_addr)
                `GIOC_CTRL_OFFSET: begin
                    next_ctrl = merged[`GIOC_CTRL_W-1:0];
                end
                `GIOC_STATUS_OFFSET: begin
                    next_bresp = `GIOC_RESP_OKAY;
                end
                default: begin
                    next_bresp = `GIOC_RESP_SLVERR;
                end
            endcase
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = `GIOC_RESP_OKAY;
            case (s_axi_araddr[`GIOC_AW-1:0])
                `GIOC_CTRL_OFFSET: begin
                    next_rdata = {{(32-`GIOC_CTRL_W){1'b0}}, ctrl};
                end
                `GIOC_STATUS_OFFSET: begin
                    next_rdata = status;
                end
                default: begin
                    next_rdata = 32'h00000000;
                    next_rresp = `GIOC_RESP_SLVERR;
                end
            endcase
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            ctrl <= `GIOC_CTRL_RESET;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `GIOC_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `GIOC_RESP_OKAY;
        end else begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            ctrl <= next_ctrl;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_arready <= next_arready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    // ===========================================================
    // Pin sampling and edge pulses
    // The cell clocks come in as levels; sampling them limits their rate
    // to well below the bus clock, traded for a single clock domain.
    always_comb begin
        next_sync1 = {global_clock_line, launch_clock, capture_clock, pad_in};
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            cap_prev <= 1'b0;
            lau_prev <= 1'b0;
        end else begin
            sync1 <= next_sync1;
            sync2 <= sync1;
            cap_prev <= cap_s2;
            lau_prev <= lau_s2;
        end
    end

    assign {glob_s2, lau_s2, cap_s2, pad_s2} = sync2;
    assign cap_rise = cap_s2 && !cap_prev;
    assign cap_fall = !cap_s2 && cap_prev;
    assign lau_rise = lau_s2 && !lau_prev;
    assign lau_fall = !lau_s2 && lau_prev;
    // Differential pins used single-ended have no double-rate registers.
    assign ddr_on = ctrl[`GIOC_DDR] && !ctrl[`GIOC_DIFF];

    // ===========================================================
    // Cell registers
    // Pad captured before the core.
    gioc_edge_reg #(.WIDTH(1)) u_in_reg (.aclk(aclk), .aresetn(aresetn),
        .rise_pulse(cap_rise), .fall_pulse(cap_fall),
        .use_fall(ctrl[`GIOC_IN_FALL]), .d(pad_s2), .q(in_q));
    gioc_edge_reg #(.WIDTH(1)) u_in_rise (.aclk(aclk), .aresetn(aresetn),
        .rise_pulse(cap_rise), .fall_pulse(cap_fall), .use_fall(1'b0),
        .d(pad_s2), .q(in_rise_q));
    gioc_edge_reg #(.WIDTH(1)) u_in_fall (.aclk(aclk), .aresetn(aresetn),
        .rise_pulse(cap_rise), .fall_pulse(cap_fall), .use_fall(1'b1),
        .d(pad_s2), .q(in_fall_q));
    // Output and enable registers on launch edges.
    gioc_edge_reg #(.WIDTH(1)) u_out_reg (.aclk(aclk), .aresetn(aresetn),
        .rise_pulse(lau_rise), .fall_pulse(lau_fall),
        .use_fall(ctrl[`GIOC_OUT_FALL]), .d(core_out[0]), .q(out_q));
    gioc_edge_reg #(.WIDTH(1)) u_oe_reg (.aclk(aclk), .aresetn(aresetn),
        .rise_pulse(lau_rise), .fall_pulse(lau_fall),
        .use_fall(ctrl[`GIOC_OE_FALL]), .d(core_oe), .q(oe_q));
    // Launch data caught on both edges.
    gioc_edge_reg #(.WIDTH(1)) u_out_rise (.aclk(aclk), .aresetn(aresetn),
        .rise_pulse(lau_rise), .fall_pulse(lau_fall), .use_fall(1'b0),
        .d(core_out[0]), .q(dout_rise_q));
    gioc_edge_reg #(.WIDTH(1)) u_out_fall (.aclk(aclk), .aresetn(aresetn),
        .rise_pulse(lau_rise), .fall_pulse(lau_fall), .use_fall(1'b1),
        .d(core_out[1]), .q(dout_fall_q));

    // ===========================================================
    // Pad and core paths
    always_comb begin
        rx_val = {1'b0, ctrl[`GIOC_IN_REG] ? in_q : pad_s2};
        if (ddr_on) begin
            rx_val = {in_fall_q, in_rise_q};
        end
        // Transmit registering chosen apart from receive.
        tx_val = ctrl[`GIOC_OUT_REG] ? out_q : core_out[0];
        if (ddr_on) begin
            // Launch level selects the half-period bit.
            tx_val = lau_s2 ? dout_rise_q : dout_fall_q;
        end
        tx_val = tx_val ^ ctrl[`GIOC_OUT_INV];
        oe_val = ctrl[`GIOC_OUT_REG] ? oe_q : core_oe;
        next_core_in = 2'h0;
        next_alt = 1'b0;
        next_pad_out = 1'b0;
        next_pad_oe = 1'b0;
        next_pull_up = 1'b0;
        next_pull_down = 1'b0;
        if (config_active) begin
            next_pull_up = !ctrl[`GIOC_DIFF];
        end else begin
            case (mode)
                gioc_pkg::mode_input: begin
                    next_core_in = rx_val;
                    // Alternate feed bypasses the core path.
                    next_alt = ctrl[`GIOC_ALT] && pad_s2;
                end
                gioc_pkg::mode_output: begin
                    next_pad_oe = oe_val;
                    next_pad_out = tx_val && oe_val;
                end
                gioc_pkg::mode_bidir: begin
                    next_core_in = rx_val;
                    next_pad_oe = oe_val;
                    // Disabled driver leaves the pad low internally.
                    next_pad_out = tx_val && oe_val;
                end
                gioc_pkg::mode_clkout: begin
                    next_pad_oe = 1'b1;
                    next_pad_out = glob_s2;
                end
                default: begin
                    // Unused pins float with the chosen pull; differential pins get no pull-down.
                    next_pull_up = !ctrl[`GIOC_PULL_DOWN];
                    next_pull_down = ctrl[`GIOC_PULL_DOWN]
                        && !ctrl[`GIOC_DIFF];
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_in <= 2'h0;
            alternate_input <= 1'b0;
            pad_out <= 1'b0;
            pad_oe <= 1'b0;
            pad_pull_up <= 1'b0;
            pad_pull_down <= 1'b0;
        end else begin
            core_in <= next_core_in;
            alternate_input <= next_alt;
            pad_out <= next_pad_out;
            pad_oe <= next_pad_oe;
            pad_pull_up <= next_pull_up;
            pad_pull_down <= next_pull_down;
        end
    end

    // ===========================================================
    // Assertions
    a_input_no_drive: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(mode == gioc_pkg::mode_input) |-> !pad_oe)
        else $error("Driver enabled in input mode.");
    a_alt_follows_pad: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(mode == gioc_pkg::mode_input && ctrl[`GIOC_ALT]
        && !config_active) |-> alternate_input == $past(pad_s2))
        else $error("Alternate input does not follow the pad.");
    a_ddr_rise_sample: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(cap_rise) |-> in_rise_q == $past(pad_s2))
        else $error("Rising sample not taken on the capture edge.");
    a_output_no_rx: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(mode == gioc_pkg::mode_output) |-> core_in == 2'h0)
        else $error("Receive path active in output mode.");
    a_out_invert: assert property (@(posedge aclk) disable iff (!aresetn)
        ($past(mode == gioc_pkg::mode_output && !config_active && !ddr_on
        && !ctrl[`GIOC_OUT_REG] && ctrl[`GIOC_OUT_INV]) && pad_oe)
        |-> pad_out == !$past(core_out[0]))
        else $error("Inverted output value wrong.");
    a_ddr_out_mux: assert property (@(posedge aclk) disable iff (!aresetn)
        ($past(mode == gioc_pkg::mode_output && !config_active && ddr_on
        && lau_s2 && !ctrl[`GIOC_OUT_INV]) && pad_oe)
        |-> pad_out == $past(dout_rise_q))
        else $error("Double-rate output mux wrong.");
    a_clkout_path: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(mode == gioc_pkg::mode_clkout && !config_active)
        |-> pad_oe && pad_out == $past(glob_s2))
        else $error("Clock output does not follow the clock line.");
    a_cfg_pull_up: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(config_active && aresetn) |-> !pad_oe && !pad_pull_down
        && pad_pull_up == !$past(ctrl[`GIOC_DIFF]))
        else $error("Configuration pull state wrong.");
    a_unused_pull: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(mode == gioc_pkg::mode_unused && !config_active && aresetn)
        |-> !pad_oe && pad_pull_up == !$past(ctrl[`GIOC_PULL_DOWN]))
        else $error("Unused pin pull state wrong.");
    a_sdr_bit_one: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(mode == gioc_pkg::mode_input && !ddr_on) |-> !core_in[1])
        else $error("Second input bit used outside double rate.");
    a_off_is_low: assert property (@(posedge aclk) disable iff (!aresetn)
        !pad_oe && !$past(mode == gioc_pkg::mode_clkout) |-> !pad_out)
        else $error("Pad data driven with the driver off.");

endmodule : gioc_cell

// ==== test/gioc_pad_model.sv ====
// Pad and far-side driver model for the I/O cell.
`timescale 1ns/1ps

module gioc_pad_model (
    input wire logic aclk,
    input wire logic pad_out,
    input wire logic pad_oe,
    input wire logic pad_pull_up,
    input wire logic pad_pull_down,
    input wire logic ext_en,
    input wire logic ext_val,
    output logic pad_in
);
    logic last = 1'h0;

    // ===========================================================
    // Pad level
    // A floating pad flips every cycle so a stale level never passes.
    // released pad level
    always_comb begin
        if (pad_oe) begin
            pad_in = pad_out;
        end else if (ext_en) begin
            pad_in = ext_val;
        end else if (pad_pull_up) begin
            pad_in = 1'h1;
        end else if (pad_pull_down) begin
            pad_in = 1'h0;
        end else begin
            pad_in = ~last;
        end
    end

    always_ff @(posedge aclk) begin
        last <= pad_in;
    end
endmodule : gioc_pad_model

// ==== test/test_gioc_cell.sv ====
// Self-checking bench for the I/O cell.
`timescale 1ns/1ps
`include "gioc_defs.svh"

module test_gioc_cell;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, config_active;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [3:0] cnt = 4'h0;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0] s_axi_bresp, s_axi_rresp, core_out, core_in, r;
    logic core_oe, alternate_input, pad_out, pad_oe, pad_in;
    logic pad_pull_up, pad_pull_down, ext_en, ext_val, ddr_pat, pa, pb;
    logic [15:0] rnd;
    int err_count, tests_run;
    wire capture_clock = cnt[3];
    wire launch_clock = cnt[3];
    wire global_clock_line = cnt[3];
    wire ext_bit = ddr_pat ? ((cnt[3] ^ cnt[2]) ? pa : pb) : ext_val;

    gioc_cell #(.ADDR_WIDTH(4)) gioc_cell_inst (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .config_active, .core_out, .core_oe,
        .capture_clock, .launch_clock, .global_clock_line, .pad_in,
        .core_in, .alternate_input, .pad_out, .pad_oe, .pad_pull_up,
        .pad_pull_down);
    gioc_pad_model gioc_pad_model_inst (.aclk, .pad_out, .pad_oe,
        .pad_pull_up, .pad_pull_down, .ext_en, .ext_val(ext_bit), .pad_in);

    // ===========================================================
    // Clocks and helpers
    // Slow pin clocks at a sixteenth of the bus clock keep edges visible.
    initial begin
        aclk = 1'h0;
        forever #2.5 aclk = ~aclk;
    end
    always @(posedge aclk) cnt <= cnt + 4'h1;
    initial begin
        repeat (8000) @(posedge aclk);
        err_count++;
        wrap_up();
    end

    function logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr
    function logic exp_pad(input logic oe, input logic v, input logic inv);
        return oe & (v ^ inv);
    endfunction : exp_pad

    task chk(input logic [31:0] g, input logic [31:0] e, input string m);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask : wr
    task rd(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        r = s_axi_rresp;
        d = s_axi_rdata;
        s_axi_rready <= 1'h0;
    endtask : rd
    task setc(input logic [12:0] c);
        wr(`GIOC_CTRL_OFFSET, {19'h0, c});
        repeat (40) @(posedge aclk);
    endtask : setc
    task phase(input logic hi, input logic lo);
        do @(posedge aclk); while (cnt != 4'hE);
        chk(pad_out, hi, "pad high phase");
        do @(posedge aclk); while (cnt != 4'h6);
        chk(pad_out, lo, "pad low phase");
    endtask : phase
    task wrap_up;
        $display("tests %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    // ===========================================================
    // Main sequence
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, config_active, core_oe} = 4'h0;
        {ext_en, ext_val, ddr_pat, pa, pb} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, core_out} = 10'h0;
        s_axi_wstrb = 4'hF;
        s_axi_wdata = 32'h0;
        rnd = 16'hE249;
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (4) @(posedge aclk);
        chk({pad_pull_up, pad_pull_down, pad_oe}, 3'h4, "unused pull");
        setc(13'h0800);
        chk({pad_pull_up, pad_pull_down}, 2'h1, "pull down");
        config_active <= 1'h1;
        repeat (8) @(posedge aclk);
        chk({pad_pull_up, pad_pull_down}, 2'h2, "config pull");
        setc(13'h1800);
        chk({pad_pull_up, pad_pull_down, pad_oe}, 3'h0, "diff float");
        config_active <= 1'h0;
        rd(`GIOC_CTRL_OFFSET);
        chk(d, 32'h1800, "ctrl readback");
        rd(4'h8);
        chk(r, `GIOC_RESP_SLVERR, "unmapped read resp");
        chk(d, 32'h0, "unmapped read data");
        wr(4'hC, 32'h1);
        chk(r, `GIOC_RESP_SLVERR, "unmapped write");
        $display("pulls and bus done");
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            ext_en <= 1'h1;
            ext_val <= rnd[3];
            setc(13'h0001 | {2'h0, rnd[2], 5'h0, rnd[1:0], 3'h0});
            chk(pad_oe, 1'h0, "input drives");
            if (!rnd[2]) chk(core_in[0], rnd[3], "input value");
            if (rnd[2]) chk(alternate_input, rnd[3], "alt");
        end
        $display("input done");
        for (int k = 0; k < 6; k++) begin
            rnd = lfsr(rnd);
            core_out <= {1'h0, rnd[5]};
            core_oe <= rnd[3];
            ext_en <= !rnd[3] && rnd[4];
            ext_val <= rnd[6];
            setc({10'h0, rnd[4] ? 3'h3 : 3'h2} |
                {4'h0, rnd[0], 1'h0, rnd[2:1], 5'h0});
            chk(pad_oe, rnd[3], "enable");
            chk(pad_out, exp_pad(rnd[3], rnd[5], rnd[0]), "out");
            if (rnd[4] && !rnd[3]) chk(core_in[0], rnd[6], "bidir");
        end
        core_out <= 2'h1;
        core_oe <= 1'h1;
        setc(13'h0102);
        chk(pad_out, 1'h0, "inverted out");
        // The double-rate input pattern only reaches the pad while driven.
        ext_en <= 1'h1;
        $display("output done");
        ddr_pat <= 1'h1;
        for (int k = 0; k < 2; k++) begin
            pa <= k[0];
            pb <= !k[0];
            setc(13'h0201);
            chk(core_in, {!k[0], k[0]}, "ddr in");
        end
        ddr_pat <= 1'h0;
        ext_en <= 1'h0;
        core_out <= 2'h1;
        core_oe <= 1'h1;
        setc(13'h0202);
        phase(1'h1, 1'h0);
        setc(13'h0004);
        phase(1'h1, 1'h0);
        chk(pad_oe, 1'h1, "clock out drives");
        $display("double rate and clock done");
        wrap_up();
    end
endmodule : test_gioc_cell
